// ---- hw/sensor_pkg.sv ----
/*
 Shared constants, register layout and types of the colour sensor
 measurement sequencer. Assumes a 20 MHz core clock.
*/
package sensor_pkg;
	// Register offsets as seen by the serial link.
	localparam logic [4:0] ADDR_ENABLE = 5'h00;
	localparam logic [4:0] ADDR_ITIME = 5'h01;
	localparam logic [4:0] ADDR_WAIT = 5'h03;
	localparam logic [4:0] ADDR_LOW_LO = 5'h04;
	localparam logic [4:0] ADDR_LOW_HI = 5'h05;
	localparam logic [4:0] ADDR_HIGH_LO = 5'h06;
	localparam logic [4:0] ADDR_HIGH_HI = 5'h07;
	localparam logic [4:0] ADDR_FILTER = 5'h0c;
	localparam logic [4:0] ADDR_CONFIG = 5'h0d;
	localparam logic [4:0] ADDR_STATUS = 5'h13;
	// Special function code that clears the pending interrupt.
	localparam logic [4:0] SF_INT_CLEAR = 5'h06;
	// Field positions.
	localparam int EN_POWER = 0;
	localparam int EN_CONV = 1;
	localparam int EN_WAIT = 3;
	localparam int EN_INT = 4;
	localparam int CFG_WAIT_LONG_SELECT = 1;
	localparam int STAT_INT = 4;
	localparam int STAT_VALID = 0;
	// Writable bits; reserved bits are dropped and read as zero.
	localparam logic [7:0] EN_MASK = 8'h1b;
	localparam logic [7:0] FILT_MASK = 8'h0f;
	localparam logic [7:0] CFG_MASK = 8'h02;
	// Reset values.
	localparam logic [7:0] ITIME_RESET = 8'hff;
	localparam logic [7:0] WAIT_RESET = 8'hff;
	// Timing: one step is 2.4 ms.
	localparam int STEP_TIME_US = 2400;
	localparam int CLK_FREQ_MHZ = 20;
	localparam int STEP_CYCLES = STEP_TIME_US * CLK_FREQ_MHZ;
	localparam int WAIT_LONG_SELECT_FACTOR = 12;
	localparam logic [8:0] STEPS_FULL = 9'h100;
	localparam int COUNT_PER_STEP = 1024;
	localparam logic [15:0] COUNT_LIMIT = 16'hffff;
	// Persistence: codes below PERS_DIRECT count as is, others by fives.
	localparam logic [3:0] PERS_DIRECT = 4'h4;
	localparam logic [3:0] PERS_OFFSET = 4'h3;
	localparam int PERS_STEP = 5;

	// Sequencer states.
	typedef enum logic [2:0] {
		SEQ_OFF, SEQ_WARM, SEQ_IDLE, SEQ_INTEG, SEQ_CHECK, SEQ_WAIT
	} seq_e;

	// Programmable settings.
	typedef struct packed {
		logic [7:0] en;
		logic [7:0] itime;
		logic [7:0] wait_interval;
		logic [15:0] low;
		logic [15:0] high;
		logic [7:0] filt;
		logic [7:0] cfg;
	} regs_s;

	localparam regs_s REGS_RST = '{en: 8'h00, itime: ITIME_RESET,
		wait_interval: WAIT_RESET, low: 16'h0000, high: 16'h0000,
		filt: 8'h00, cfg: 8'h00};

	// One write or special function passing between the clock domains.
	typedef struct packed {
		logic sf;
		logic [4:0] addr;
		logic [7:0] data;
	} wr_msg_s;

	// Applies one register write; thresholds are assembled bytewise.
	function automatic regs_s reg_write(regs_s r, logic [4:0] a,
		logic [7:0] d);
		regs_s n;
		n = r;
		case (a)
			ADDR_ENABLE: n.en = d & EN_MASK;
			ADDR_ITIME: n.itime = d;
			ADDR_WAIT: n.wait_interval = d;
			ADDR_LOW_LO: n.low[7:0] = d;
			ADDR_LOW_HI: n.low[15:8] = d;
			ADDR_HIGH_LO: n.high[7:0] = d;
			ADDR_HIGH_HI: n.high[15:8] = d;
			ADDR_FILTER: n.filt = d & FILT_MASK;
			ADDR_CONFIG: n.cfg = d & CFG_MASK;
			default: n = r;
		endcase
		return n;
	endfunction
endpackage

// ---- hw/wr_msg_if.sv ----
/*
 Carries accepted register writes into the core clock domain.
 Assumes valid is a one-cycle pulse on the core clock.
*/
`timescale 1ns/1ps
interface wr_msg_if
	import sensor_pkg::*;
;
	logic valid; // One pulse per delivered message.
	wr_msg_s msg; // Message, stable while valid.
	modport src (output valid, output msg);
	modport dst (input valid, input msg);
endinterface

// ---- hw/msg_crossing.sv ----
/*
 Toggle handshake that moves one message from the link clock domain
 into the core domain. Assumes both resets come from one source.
*/
`timescale 1ns/1ps
module msg_crossing
	import sensor_pkg::*;
(
	input wire logic link_clk_i,
	input wire logic link_rst_i,
	input wire logic send_i,
	input wr_msg_s msg_i,
	output logic busy_o,
	input wire logic clock_i,
	input wire logic reset_i,
	wr_msg_if.src out
);
	// Link side: request toggle, held message, acknowledge sync.
	typedef struct packed {
		logic req;
		logic ack1;
		logic ack2;
		logic busy;
		wr_msg_s msg;
	} lnk_s;
	// Core side: request sync, edge detect, delivered message.
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic valid;
		wr_msg_s msg;
	} cor_s;
	lnk_s lq, ln;
	cor_s cq, cn;

	////////////////////////////////////////////////////////////////////
	// A new message is refused while the previous one is in flight;
	// this keeps the held message stable while the core samples it.
	always_comb begin
		ln = lq;
		ln.ack1 = cq.s3;
		ln.ack2 = lq.ack1;
		if (send_i && !lq.busy) begin
			ln.req = ~lq.req;
			ln.msg = msg_i;
		end
		ln.busy = ln.req != ln.ack2;
		if (link_rst_i) begin
			ln = '0;
		end
	end

	always_ff @(posedge link_clk_i) begin
		lq <= ln;
	end

	////////////////////////////////////////////////////////////////////
	// Only the second and third flops feed the edge detector.
	always_comb begin
		cn = cq;
		cn.s1 = lq.req;
		cn.s2 = cq.s1;
		cn.s3 = cq.s2;
		cn.valid = cq.s2 ^ cq.s3;
		if (cq.s2 ^ cq.s3) begin
			cn.msg = lq.msg;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cq <= '0;
		end else begin
			cq <= cn;
		end
	end

	assign busy_o = lq.busy;
	assign out.valid = cq.valid;
	assign out.msg = cq.msg;
endmodule // msg_crossing

// ---- hw/persist_filter.sv ----
/*
 Threshold compare and persistence filter for the clear channel.
 Assumes sample_i pulses once per finished conversion.
*/
`timescale 1ns/1ps
module persist_filter
	import sensor_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic sample_i,
	input wire logic [15:0] value_i,
	input wire logic [15:0] low_i,
	input wire logic [15:0] high_i,
	input wire logic [3:0] code_i,
	output logic hit_o
);
	typedef struct packed {
		logic [5:0] cnt; // Consecutive out-of-range results.
		logic hit; // Interrupt request, one pulse.
	} pf_s;
	pf_s q, n;
	logic out_range; // Result lies outside the window.
	logic [5:0] need; // Results needed to fire.

	////////////////////////////////////////////////////////////////////
	// window compare
	assign out_range = (value_i < low_i) || (value_i > high_i);

	always_comb begin
		if (code_i < PERS_DIRECT) begin
			need = {2'b00, code_i};
		end else begin
			need = 6'((code_i - PERS_OFFSET) * PERS_STEP);
		end
	end

	// The count saturates so that it never wraps back into range.
	always_comb begin
		n = q;
		n.hit = 1'b0;
		if (sample_i) begin
			if (!out_range) begin
				n.cnt = 6'h00;
			end else if (q.cnt != 6'h3f) begin
				n.cnt = q.cnt + 6'h01;
			end
			if (code_i == 4'h0) begin
				n.hit = 1'b1;
			end else if (out_range && (7'(q.cnt) + 7'h01 >= 7'(need)))
				begin
				n.hit = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign hit_o = q.hit;

	property p_every;
		@(posedge clock_i) disable iff (reset_i)
		(sample_i && code_i == 4'h0) |=> hit_o;
	endproperty
	a_every: assert property (p_every)
		else $error("no interrupt on code zero");

	property p_single;
		@(posedge clock_i) disable iff (reset_i)
		(sample_i && code_i == 4'h1 && out_range) |=> hit_o;
	endproperty
	a_single: assert property (p_single)
		else $error("single out-of-range result missed");

	property p_early;
		@(posedge clock_i) disable iff (reset_i)
		(sample_i && out_range && code_i != 4'h0 &&
			7'(q.cnt) + 7'h01 < 7'(need)) |=> !hit_o;
	endproperty
	a_early: assert property (p_early)
		else $error("interrupt before persistence count");

	property p_restart;
		@(posedge clock_i) disable iff (reset_i)
		(sample_i && !out_range && code_i != 4'h0)
			|=> (q.cnt == 6'h00 && !hit_o);
	endproperty
	a_restart: assert property (p_restart)
		else $error("count not restarted in range");
endmodule // persist_filter

// ---- hw/color_sensor_measure_sequencer.sv ----
/*
 Measurement sequencer of a colour light sensor: power-up delay,
 integration and wait timing, clear channel thresholds, persistence
 and the interrupt level. Registers are written and read from the
 serial link front end, on the link clock. The analog front end
 presents the clear channel count on clear_data_i in the core domain.
*/
// Behaviour
// - Power bit runs oscillator, timers and conversions.
// - Conversion bit starts and stops colour conversion.
// - Wait bit adds a wait between cycles.
// - Interrupt pin raised only while enabled.
// - Integration lasts 256 minus value steps.
// - Max count steps times 1024, saturating.
// - Wait steps are 2.4 ms, long mode twelvefold.
// - Wait lasts 256 minus value steps.
// - Clear result outside thresholds is out of range.
// - Thresholds are sixteen bits from two bytes.
// - Filter code in low nibble, rest reserved.
// - Code zero interrupts every cycle.
// - Code one interrupts on one result.
// - Codes two and three need consecutive results.
// - Higher codes need five to sixty results.
// - Special function clears the pending interrupt.
// - Status bit four shows interrupt state.
// - Status bit zero shows integration done.
// - Config bit one selects long wait.
`timescale 1ns/1ps
module color_sensor_measure_sequencer
	import sensor_pkg::*;
#(
	parameter int STEP_CYCLES_P = STEP_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic link_clk_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic sf_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [15:0] clear_data_i,
	output logic [7:0] rd_data_o,
	output logic link_busy_o,
	output logic osc_on_o,
	output logic adc_run_o,
	output logic wait_active_o,
	output logic [15:0] clear_result_o,
	output logic int_o
);
	////////////////////////////////////////////////////////////////////
	// State of the core domain.
	typedef struct packed {
		regs_s regs; // Settings as the core uses them.
		seq_e state; // Sequencer state.
		logic [15:0] tick_cnt; // Cycles within the current step.
		logic [11:0] steps; // Steps left in the current phase.
		logic [15:0] clear; // Last clamped clear result.
		logic flag; // Pending clear channel interrupt.
		logic valid; // An integration has completed.
		logic sample; // Pulse: new result for the filter.
		logic int_out; // Interrupt pin level.
		logic adc_run; // Integration in progress.
		logic waiting; // Wait timer running.
	} core_s;

	// State of the link domain.
	typedef struct packed {
		logic rs1; // Reset synchroniser, first flop.
		logic rs2; // Reset synchroniser, second flop.
		regs_s regs; // Read-back copy of the settings.
		logic int1; // Interrupt flag sync, first flop.
		logic int2; // Interrupt flag sync, second flop.
		logic val1; // Valid flag sync, first flop.
		logic val2; // Valid flag sync, second flop.
		logic [7:0] rd_data; // Read data register.
	} link_s;

	localparam core_s CORE_RST = '{regs: REGS_RST, state: SEQ_OFF,
		default: '0};

	core_s cq, cn;
	link_s lq, ln;
	wr_msg_if wr_if ();
	logic tick; // Last cycle of a 2.4 ms step.
	logic hit; // Persistence filter fired.
	logic clr_evt; // Interrupt clear arrived.
	logic send; // Link asks for a crossing.
	logic link_busy; // Crossing still in flight.
	wr_msg_s send_msg; // Message offered to the crossing.
	logic [11:0] integ_steps; // Steps of one integration.
	logic [11:0] wait_base; // Programmed wait steps.
	logic [11:0] wait_steps; // Wait steps after long mode.
	logic [18:0] count_full; // Unsaturated largest count.
	logic [15:0] max_count; // Largest count a channel reaches.
	logic [15:0] clamped; // Clear input limited to max_count.

	////////////////////////////////////////////////////////////////////
	// Link domain: read-back copy, status sync and read data.
	// The copy is updated only when the crossing accepts the write, so
	// what the host reads back is what the core will use.
	assign send_msg = '{sf: sf_i, addr: reg_addr_i, data: reg_wdata_i};
	assign send = ((reg_wr_i && !sf_i) ||
		(sf_i && reg_addr_i == SF_INT_CLEAR)) && !lq.rs2;

	always_comb begin
		ln = lq;
		ln.rs1 = reset_i;
		ln.rs2 = lq.rs1;
		ln.int1 = cq.flag;
		ln.int2 = lq.int1;
		ln.val1 = cq.valid;
		ln.val2 = lq.val1;
		if (reg_wr_i && !sf_i && !link_busy) begin
			ln.regs = reg_write(lq.regs, reg_addr_i, reg_wdata_i);
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_ENABLE: ln.rd_data = lq.regs.en;
				ADDR_ITIME: ln.rd_data = lq.regs.itime;
				ADDR_WAIT: ln.rd_data = lq.regs.wait_interval;
				ADDR_LOW_LO: ln.rd_data = lq.regs.low[7:0];
				ADDR_LOW_HI: ln.rd_data = lq.regs.low[15:8];
				ADDR_HIGH_LO: ln.rd_data = lq.regs.high[7:0];
				ADDR_HIGH_HI: ln.rd_data = lq.regs.high[15:8];
				ADDR_FILTER: ln.rd_data = lq.regs.filt;
				ADDR_CONFIG: ln.rd_data = lq.regs.cfg;
				ADDR_STATUS: begin
					ln.rd_data = 8'h00;
					ln.rd_data[STAT_INT] = lq.int2;
					ln.rd_data[STAT_VALID] = lq.val2;
				end
				default: ln.rd_data = 8'h00;
			endcase
		end
		if (lq.rs2) begin
			ln.regs = REGS_RST;
			ln.rd_data = 8'h00;
		end
	end

	// The reset synchroniser flops carry no reset of their own.
	always_ff @(posedge link_clk_i) begin
		lq <= ln;
	end

	msg_crossing u_cross (
		.link_clk_i(link_clk_i),
		.link_rst_i(lq.rs2),
		.send_i(send),
		.msg_i(send_msg),
		.busy_o(link_busy),
		.clock_i(clock_i),
		.reset_i(reset_i),
		.out(wr_if)
	);

	////////////////////////////////////////////////////////////////////
	// Derived timing figures from the current settings.
	assign tick = cq.tick_cnt == 16'(STEP_CYCLES_P - 1);
	assign integ_steps = {3'b000, STEPS_FULL - {1'b0, cq.regs.itime}};
	assign wait_base = {3'b000, STEPS_FULL - {1'b0, cq.regs.wait_interval}};
	assign wait_steps = cq.regs.cfg[CFG_WAIT_LONG_SELECT] ?
		12'(wait_base * 12'(WAIT_LONG_SELECT_FACTOR)) : wait_base;
	assign count_full = 19'(integ_steps) * 19'(COUNT_PER_STEP);
	assign max_count = (count_full > 19'(COUNT_LIMIT)) ? COUNT_LIMIT :
		count_full[15:0];
	assign clamped = (clear_data_i > max_count) ? max_count : clear_data_i;
	assign clr_evt = wr_if.valid && wr_if.msg.sf;

	////////////////////////////////////////////////////////////////////
	// Core sequencer. One step counter serves warm-up, integration and
	// wait; it restarts on every state change so each phase is whole.
	always_comb begin
		cn = cq;
		cn.sample = 1'b0;
		if (wr_if.valid && !wr_if.msg.sf) begin
			cn.regs = reg_write(cq.regs, wr_if.msg.addr, wr_if.msg.data);
		end
		if (!cq.regs.en[EN_POWER] || tick) begin
			cn.tick_cnt = 16'h0000;
		end else begin
			cn.tick_cnt = cq.tick_cnt + 16'h0001;
		end
		unique case (cq.state)
			SEQ_OFF: begin
				if (cq.regs.en[EN_POWER]) begin
					cn.state = SEQ_WARM;
				end
			end
			SEQ_WARM: begin
				if (tick) begin
					cn.state = SEQ_IDLE;
				end
			end
			SEQ_IDLE: begin
				if (cq.regs.en[EN_CONV]) begin
					cn.state = SEQ_INTEG;
					cn.steps = integ_steps;
				end
			end
			SEQ_INTEG: begin
				if (tick && cq.steps == 12'h001) begin
					cn.state = SEQ_CHECK;
					cn.clear = clamped;
					cn.valid = 1'b1;
					cn.sample = 1'b1;
				end else if (tick) begin
					cn.steps = cq.steps - 12'h001;
				end
			end
			SEQ_CHECK: begin
				if (cq.regs.en[EN_WAIT]) begin
					cn.state = SEQ_WAIT;
					cn.steps = wait_steps;
				end else begin
					cn.state = SEQ_INTEG;
					cn.steps = integ_steps;
				end
			end
			SEQ_WAIT: begin
				if (tick && cq.steps == 12'h001) begin
					cn.state = SEQ_INTEG;
					cn.steps = integ_steps;
				end else if (tick) begin
					cn.steps = cq.steps - 12'h001;
				end
			end
		endcase
		if (!cq.regs.en[EN_POWER]) begin
			cn.state = SEQ_OFF;
			cn.valid = 1'b0;
		end else if (!cq.regs.en[EN_CONV] && cq.state != SEQ_OFF &&
			cq.state != SEQ_WARM) begin
			cn.state = SEQ_IDLE;
		end
		if (cn.state != cq.state) begin
			cn.tick_cnt = 16'h0000;
		end
		cn.flag = (cq.flag && !clr_evt) || hit;
		cn.int_out = cq.flag && cq.regs.en[EN_INT];
		cn.adc_run = cn.state == SEQ_INTEG;
		cn.waiting = cn.state == SEQ_WAIT;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cq <= CORE_RST;
		end else begin
			cq <= cn;
		end
	end

	persist_filter u_filter (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.sample_i(cq.sample),
		.value_i(cq.clear),
		.low_i(cq.regs.low),
		.high_i(cq.regs.high),
		.code_i(cq.regs.filt[3:0]),
		.hit_o(hit)
	);

	assign rd_data_o = lq.rd_data;
	assign link_busy_o = link_busy;
	assign osc_on_o = cq.regs.en[EN_POWER];
	assign adc_run_o = cq.adc_run;
	assign wait_active_o = cq.waiting;
	assign clear_result_o = cq.clear;
	assign int_o = cq.int_out;

	////////////////////////////////////////////////////////////////////
	// Checks on the sequencer.
	property p_power_off;
		@(posedge clock_i) disable iff (reset_i)
		!cq.regs.en[EN_POWER] |=> (cq.state == SEQ_OFF && !adc_run_o);
	endproperty
	a_power_off: assert property (p_power_off)
		else $error("sequencer runs without power");

	property p_conv_off;
		@(posedge clock_i) disable iff (reset_i)
		(cq.regs.en[1:0] == 2'b01 && cq.state == SEQ_INTEG)
			|=> cq.state == SEQ_IDLE;
	endproperty
	a_conv_off: assert property (p_conv_off)
		else $error("conversion not stopped");

	property p_wait_skip;
		@(posedge clock_i) disable iff (reset_i)
		(cq.state == SEQ_CHECK && cq.regs.en[1:0] == 2'b11 &&
			!cq.regs.en[EN_WAIT]) |=> cq.state == SEQ_INTEG;
	endproperty
	a_wait_skip: assert property (p_wait_skip)
		else $error("wait entered while disabled");

	property p_int_gate;
		@(posedge clock_i) disable iff (reset_i)
		int_o |-> $past(cq.regs.en[EN_INT]) && $past(cq.flag);
	endproperty
	a_int_gate: assert property (p_int_gate)
		else $error("interrupt raised while masked");

	property p_integ_len;
		@(posedge clock_i) disable iff (reset_i)
		(cq.state != SEQ_INTEG ##1 cq.state == SEQ_INTEG)
			|-> cq.steps == $past(integ_steps);
	endproperty
	a_integ_len: assert property (p_integ_len)
		else $error("wrong integration length");

	property p_clamp;
		@(posedge clock_i) disable iff (reset_i)
		cq.sample |-> cq.clear <= $past(max_count);
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("result above largest count");

	property p_wait_len;
		@(posedge clock_i) disable iff (reset_i)
		(cq.state != SEQ_WAIT ##1 cq.state == SEQ_WAIT)
			|-> cq.steps == $past(wait_steps);
	endproperty
	a_wait_len: assert property (p_wait_len)
		else $error("wrong wait length");

	property p_warm_hold;
		@(posedge clock_i) disable iff (reset_i)
		(cq.state == SEQ_WARM && !tick && cq.regs.en[EN_POWER])
			|=> cq.state == SEQ_WARM;
	endproperty
	a_warm_hold: assert property (p_warm_hold)
		else $error("warm-up cut short");

	property p_flag_hold;
		@(posedge clock_i) disable iff (reset_i)
		(cq.flag && !clr_evt) |=> cq.flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("interrupt dropped without clear");

	property p_flag_clear;
		@(posedge clock_i) disable iff (reset_i)
		(clr_evt && !hit) |=> !cq.flag ##1 !int_o;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("interrupt clear ignored");

	property p_valid;
		@(posedge clock_i) disable iff (reset_i)
		(cq.state == SEQ_INTEG && tick && cq.steps == 12'h001 &&
			cq.regs.en[1:0] == 2'b11) |=> (cq.valid && cq.sample);
	endproperty
	a_valid: assert property (p_valid)
		else $error("done flag not set");

	property p_status_read;
		@(posedge link_clk_i) disable iff (lq.rs2)
		(reg_rd_i && reg_addr_i == ADDR_STATUS)
			|=> rd_data_o[STAT_INT] == $past(lq.int2);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read wrong interrupt bit");
endmodule // color_sensor_measure_sequencer

// ---- verif/link_host.sv ----
/* Host model on the register link.
 Assumes requests are sampled on rising link edges. */
`timescale 1ns/1ps
module link_host
	import sensor_pkg::*;
(
	input wire logic link_clk_i,
	input wire logic busy_i,
	input wire logic [7:0] rd_data_i,
	output logic wr_o,
	output logic rd_o,
	output logic sf_o,
	output logic [4:0] addr_o,
	output logic [7:0] data_o
);
	// Idle lines carry junk, so a stale address is never mistaken.
	initial begin
		{wr_o, rd_o, sf_o} = 3'b000;
		addr_o = 5'h1f;
		data_o = 8'h00;
	end
	// Writes or special function once the crossing is idle.
	task automatic put(input logic s, input logic [4:0] a,
		input logic [7:0] d);
		@(negedge link_clk_i);
		while (busy_i !== 1'b0) @(negedge link_clk_i);
		data_o = (a == ADDR_ENABLE && !s) ? (d & 8'h1b) : d;
		addr_o = a;
		{wr_o, sf_o} = {1'b1, s};
		@(negedge link_clk_i);
		{wr_o, sf_o} = 2'b00;
		addr_o = ~a;
		data_o = ~data_o;
	endtask
	// Reads one register; data is taken a full edge after the request.
	task automatic get(input logic [4:0] a, output logic [7:0] d);
		@(negedge link_clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge link_clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		@(negedge link_clk_i);
		d = rd_data_i;
	endtask
endmodule // link_host

// ---- verif/color_sensor_measure_sequencer_bench.sv ----
/* Self-checking bench of the measurement sequencer.
 Assumes a short step of 20 core cycles. */
`timescale 1ns/1ps
module color_sensor_measure_sequencer_bench;
	import sensor_pkg::*;
	logic clock_i = 1'b0, reset_i = 1'b1, lclk = 1'b0;
	logic wr, rd, sf, busy, osc, adc, wt, irq;
	logic [4:0] addr;
	logic [7:0] wdata, rdata;
	logic [15:0] cdata = 16'h0050, res;
	int bad_count = 0, samples_checked = 0, hi;
	logic [4:0] ra [8] = '{ADDR_ENABLE, ADDR_ITIME, ADDR_WAIT,
		ADDR_LOW_LO, ADDR_HIGH_HI, ADDR_FILTER, ADDR_CONFIG, 5'h02};
	logic [7:0] rv [8] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};
	////////////////////////////////////////////////////////////////
	// Core clock, and a link clock with an odd phase offset.
	always #25 clock_i = ~clock_i;
	initial #7 forever #62.5 lclk = ~lclk;
	color_sensor_measure_sequencer #(.STEP_CYCLES_P(20)) dut (
		.clock_i(clock_i), .reset_i(reset_i), .link_clk_i(lclk),
		.reg_wr_i(wr), .reg_rd_i(rd), .sf_i(sf), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .clear_data_i(cdata), .rd_data_o(rdata),
		.link_busy_o(busy), .osc_on_o(osc), .adc_run_o(adc),
		.wait_active_o(wt), .clear_result_o(res), .int_o(irq));
	link_host host (.link_clk_i(lclk), .busy_i(busy),
		.rd_data_i(rdata), .wr_o(wr), .rd_o(rd), .sf_o(sf),
		.addr_o(addr), .data_o(wdata));
	////////////////////////////////////////////////////////////////
	// Compares one value and counts it.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.get(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask
	// Counts the next whole pulse of the chosen output, so a pulse that
	// began before a setting landed is never measured; a bound stops a
	// hang.
	task automatic span(input bit w);
		int n;
		n = 0;
		hi = 0;
		while ((w ? wt : adc) === 1'b1 && n < 9000) begin
			@(negedge clock_i);
			n++;
		end
		while ((w ? wt : adc) !== 1'b1 && n < 9000) begin
			@(negedge clock_i);
			n++;
		end
		while ((w ? wt : adc) === 1'b1 && n < 9000) begin
			@(negedge clock_i);
			n++;
			hi++;
		end
		// Long enough for the status flags to cross into the link domain.
		repeat (10) @(negedge clock_i);
	endtask
	task automatic results;
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog well beyond the hundred or so steps the tests need.
	initial begin
		#2000000;
		bad_count++;
		results;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clock_i);
		reset_i = 1'b0;
		repeat (4) @(negedge lclk);
		for (int i = 0; i < 8; i++) rdchk(ra[i], rv[i]);
		host.put(0, ADDR_FILTER, 8'hff);
		rdchk(ADDR_FILTER, 8'h0f);
		host.put(0, ADDR_CONFIG, 8'hff);
		rdchk(ADDR_CONFIG, 8'h02);
		$display("test registers done");
		host.put(0, ADDR_LOW_HI, 8'h01);
		host.put(0, ADDR_HIGH_HI, 8'h02);
		rdchk(ADDR_LOW_HI, 8'h01);
		host.put(0, ADDR_FILTER, 8'h02);
		host.put(0, ADDR_ENABLE, 8'h13);
		span(0);
		chk(osc, 1);
		chk(irq, 0);
		chk(res, 16'h0050);
		span(0);
		chk(irq, 1);
		rdchk(ADDR_STATUS, 8'h11);
		host.put(0, ADDR_ENABLE, 8'h03);
		repeat (12) @(negedge clock_i);
		chk(irq, 0);
		cdata = 16'h0150;
		host.put(0, ADDR_ENABLE, 8'h13);
		repeat (12) @(negedge clock_i);
		chk(irq, 1);
		host.put(1, SF_INT_CLEAR, 8'h00);
		span(0);
		span(0);
		chk(irq, 0);
		// Code one: the very first result out of range fires.
		host.put(0, ADDR_FILTER, 8'h01);
		span(0);
		cdata = 16'h0050;
		@(negedge adc);
		repeat (5) @(negedge clock_i);
		chk(irq, 1);
		// Code four needs five in a row; an in-range pair restarts it.
		// Each span takes in two results.
		host.put(0, ADDR_FILTER, 8'h04);
		cdata = 16'h0150;
		span(0);
		host.put(1, SF_INT_CLEAR, 8'h00);
		cdata = 16'h0050;
		span(0);
		cdata = 16'h0150;
		span(0);
		cdata = 16'h0050;
		span(0);
		span(0);
		chk(irq, 0);
		span(0);
		chk(irq, 1);
		cdata = 16'h0150;
		host.put(1, SF_INT_CLEAR, 8'h00);
		span(0);
		chk(irq, 0);
		$display("test persistence done");
		host.put(0, ADDR_FILTER, 8'h00);
		span(0);
		chk(irq, 1);
		cdata = 16'hffff;
		host.put(0, ADDR_ITIME, 8'hfe);
		span(0);
		span(0);
		chk(hi, 40);
		chk(res, 16'h0800);
		host.put(0, ADDR_ENABLE, 8'h1b);
		span(1);
		chk(hi, 240);
		host.put(0, ADDR_CONFIG, 8'h00);
		span(1);
		span(1);
		chk(hi, 20);
		host.put(0, ADDR_ENABLE, 8'h00);
		repeat (12) @(negedge clock_i);
		chk({osc, adc}, 0);
		$display("test timing done");
		results;
	end
endmodule // color_sensor_measure_sequencer_bench
